/* File: src/ipta_arbiter.sv */
`timescale 1ns/100ps
module ipta_arbiter (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic [31:0]        wb_adr_i,
    input  wire logic [31:0]        wb_dat_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic               wb_we_i,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    input  wire logic [53:0]        src_event,
    input  wire logic               instr_done,
    input  wire ipta_pkg::ipta_math_s math_in,
    input  wire ipta_pkg::ipta_err_s  err_in,
    output ipta_pkg::ipta_req_s     core_req,
    output logic                    core_reset,
    output logic [23:0]             program_counter
);
    import ipta_pkg::*;

    logic [15:0] priority_select_regs [N_REG];
    logic [53:0] flag_q;
    logic [53:0] en_q;
    logic [3:0]  cpu_priority_level_q;
    logic [1:0]  math_en_q;
    logic        math_pend_q;
    logic        addr_pend_q;
    logic [3:0]  trap_lvl_q;
    logic        trap_active_q;
    logic [1:0]  boot_q;
    ipta_req_s   win_d;
    logic        wr;
    logic        rd;
    logic [7:0]  a;
    logic [3:0]  pidx;

    function automatic logic [2:0] prio_of(input int n);
        logic [15:0] r;
        r = priority_select_regs[n/4];
        return r[(n%4)*4 +: 3];
    endfunction : prio_of

    assign a    = wb_adr_i[7:0];
    assign pidx = a[5:2];
    assign wr   = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign rd   = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

    // priority registers
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < N_REG; i++) begin
                priority_select_regs[i] <= PRIO_RESET;
            end
        end else if (wr && a < A_FLAG0 && pidx < 4'(N_REG)) begin
            if (wb_sel_i[0])
                priority_select_regs[pidx][7:0] <=
                    wb_dat_i[7:0] & 8'h77;
            if (wb_sel_i[1])
                priority_select_regs[pidx][15:8] <=
                    wb_dat_i[15:8] & 8'h77;
        end
    end

    // flags: hardware set wins over software clear
    always_ff @(posedge clk) begin
        logic [53:0] clr;
        clr = '0;
        if (wr && a == A_FLAG0) clr[31:0] = wb_dat_i;
        if (wr && a == A_FLAG1) clr[53:32] = wb_dat_i[21:0];
        if (rst) flag_q <= '0;
        else flag_q <= ((flag_q & ~clr) | src_event) & SRC_PRESENT;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            en_q                 <= '0;
            cpu_priority_level_q <= '0;
            math_en_q            <= '0;
        end else if (wr) begin
            case (a)
                A_EN0:    en_q[31:0]  <= wb_dat_i;
                A_EN1:    en_q[53:32] <= wb_dat_i[21:0];
                A_CPUIPL: cpu_priority_level_q <= wb_dat_i[3:0];
                A_TRAPCTL: math_en_q <= wb_dat_i[1:0];
                default: ;
            endcase
        end
    end

    // arbitration
    always_comb begin
        logic [2:0] p;
        logic [3:0] ceil;
        p = '0;
        win_d = '0;
        ceil = trap_active_q ? trap_lvl_q : cpu_priority_level_q;
        for (int n = N_SRC - 1; n >= 0; n--) begin
            p = prio_of(n);
            if (flag_q[n] && en_q[n] && SRC_PRESENT[n]
                && p != 3'h0
                && {1'b0, p} > ceil
                && (!win_d.valid || p >= win_d.lvl[2:0])) begin
                win_d.valid = 1'b1;
                win_d.vec   = 6'(n) + VEC_BASE;
                win_d.lvl   = {1'b0, p};
            end
        end
        if (addr_pend_q && !(trap_active_q && trap_lvl_q >= 4'hc)) begin
            win_d.valid = 1'b1;
            win_d.vec   = 6'h03;
            win_d.lvl   = 4'hc;
        end else if (math_pend_q
                     && !(trap_active_q && trap_lvl_q >= LVL_MATH)) begin
            win_d.valid = 1'b1;
            win_d.vec   = 6'h05;
            win_d.lvl   = LVL_MATH;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) core_req <= '0;
        else core_req <= win_d;
    end

    // traps: latched and taken when the instruction completes
    always_ff @(posedge clk) begin
        logic m;
        m = math_in.div_zero
            || (math_en_q[0] && math_in.ovf31 && !math_in.guard_used)
            || (math_en_q[1] && math_in.ovf39 && !math_in.sat_on)
            || math_in.shift_over;
        if (rst) begin
            math_pend_q   <= 1'b0;
            addr_pend_q   <= 1'b0;
            trap_active_q <= 1'b0;
            trap_lvl_q    <= '0;
        end else begin
            if (m) math_pend_q <= 1'b1;
            if (err_in.bad_vector) addr_pend_q <= 1'b1;
            if (instr_done && core_req.valid && core_req.lvl[3]) begin
                trap_active_q <= 1'b1;
                trap_lvl_q    <= core_req.lvl;
                if (core_req.lvl == LVL_MATH) math_pend_q <= m;
                else addr_pend_q <= err_in.bad_vector;
            end
        end
    end

    // reset sources and vector entry
    always_ff @(posedge clk) begin
        if (rst) begin
            core_reset      <= 1'b1;
            program_counter <= RESET_ADDR;
            boot_q          <= 2'h0;
        end else begin
            core_reset <= err_in.wdt || err_in.uninit_w
                || (err_in.illegal_op && !err_in.op_flushed)
                || err_in.brownout
                || (math_pend_q && addr_pend_q);
            if (core_reset) begin
                program_counter <= RESET_ADDR;
                boot_q          <= 2'h0;
            end else if (boot_q != 2'h2) begin
                boot_q <= boot_q + 2'h1;
                program_counter <= program_counter + 24'h2;
            end
        end
    end

    // wishbone slave, one wait state
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (rd) begin
                if (a < A_FLAG0)
                    wb_dat_o <= pidx < 4'(N_REG) ?
                        {16'h0, priority_select_regs[pidx]} : '0;
                else case (a)
                    A_FLAG0:   wb_dat_o <= flag_q[31:0];
                    A_FLAG1:   wb_dat_o <= {10'h0, flag_q[53:32]};
                    A_EN0:     wb_dat_o <= en_q[31:0];
                    A_EN1:     wb_dat_o <= {10'h0, en_q[53:32]};
                    A_CPUIPL:  wb_dat_o <= {28'h0, cpu_priority_level_q};
                    A_TRAPCTL: wb_dat_o <= {30'h0, math_en_q};
                    A_ANSWER:  wb_dat_o <= {21'h0, core_req};
                    A_TRAPSTAT: wb_dat_o <= {25'h0, trap_active_q,
                        trap_lvl_q, addr_pend_q, math_pend_q};
                    default:   wb_dat_o <= '0;
                endcase
            end
        end
    end

    win_valid_a: assert property (@(posedge clk) disable iff (rst)
        core_req.valid && !core_req.lvl[3] |-> core_req.lvl != 4'h0)
        else $error("zero priority granted");
    vec_map_a: assert property (@(posedge clk) disable iff (rst)
        core_req.valid && !core_req.lvl[3] |->
        core_req.vec >= 6'h08 && core_req.vec <= 6'h3d)
        else $error("vector out of range");
    above_ipl_a: assert property (@(posedge clk) disable iff (rst)
        core_req.valid && !core_req.lvl[3] && !trap_active_q |->
        core_req.lvl > $past(cpu_priority_level_q))
        else $error("granted at or below level");
    block_all_a: assert property (@(posedge clk) disable iff (rst)
        $past(cpu_priority_level_q) == 4'h7 && core_req.valid |->
        core_req.lvl[3])
        else $error("interrupt past level seven");
    trap_lvl_a: assert property (@(posedge clk) disable iff (rst)
        trap_active_q |-> trap_lvl_q[3])
        else $error("trap below level eight");
    lockout_a: assert property (@(posedge clk) disable iff (rst)
        math_pend_q && addr_pend_q |=> core_reset)
        else $error("no lockout reset");
    div_trap_a: assert property (@(posedge clk) disable iff (rst)
        math_in.div_zero |=> math_pend_q)
        else $error("divide by zero missed");
    flushed_op_a: assert property (@(posedge clk) disable iff (rst)
        err_in.op_flushed && !err_in.wdt && !err_in.uninit_w
        && !err_in.brownout && !(math_pend_q && addr_pend_q) |=>
        !core_reset)
        else $error("flushed opcode reset");
    reset_pc_a: assert property (@(posedge clk) disable iff (rst)
        core_reset |=> program_counter == 24'h0)
        else $error("pc not zero after reset");
    bit3_zero_a: assert property (@(posedge clk) disable iff (rst)
        (priority_select_regs[0] & 16'h8888) == 16'h0)
        else $error("nibble bit three set");
endmodule : ipta_arbiter

/* File: src/ipta_pkg.sv */
package ipta_pkg;
    localparam int N_SRC        = 54;
    localparam int N_REG        = 14;
    localparam logic [5:0] VEC_BASE = 6'h08;
    localparam logic [3:0] IPL_BLOCK_ALL = 4'h7;
    localparam logic [23:0] RESET_ADDR = 24'h000000;
    localparam logic [53:0] SRC_PRESENT =
        {11'h000, 2'h3, 2'h0, 39'h7fffffffff};
    // wishbone map (byte addresses)
    localparam logic [7:0] A_PRIO_BASE = 8'h00;
    localparam logic [7:0] A_FLAG0     = 8'h40;
    localparam logic [7:0] A_FLAG1     = 8'h44;
    localparam logic [7:0] A_EN0       = 8'h48;
    localparam logic [7:0] A_EN1       = 8'h4c;
    localparam logic [7:0] A_CPUIPL    = 8'h50;
    localparam logic [7:0] A_TRAPCTL   = 8'h54;
    localparam logic [7:0] A_ANSWER    = 8'h58;
    localparam logic [7:0] A_TRAPSTAT  = 8'h5c;
    localparam logic [15:0] PRIO_RESET = 16'h4444;
    localparam logic [3:0] LVL_MATH    = 4'hb;

    typedef struct packed {
        logic       valid;
        logic [5:0] vec;
        logic [3:0] lvl;
    } ipta_req_s;

    typedef struct packed {
        logic div_zero;
        logic ovf31;
        logic guard_used;
        logic ovf39;
        logic sat_on;
        logic shift_over;
    } ipta_math_s;

    typedef struct packed {
        logic wdt;
        logic uninit_w;
        logic illegal_op;
        logic op_flushed;
        logic brownout;
        logic bad_vector;
    } ipta_err_s;
endpackage : ipta_pkg

/* File: tb/ipta_core_model.sv */
`timescale 1ns/100ps
module ipta_core_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic slow,
    input  wire logic core_reset,
    output logic      instr_done
);
    logic [1:0] cnt_q;

    // one instruction per cycle, or one in four when slow
    always_ff @(posedge clk) begin
        if (rst || core_reset) begin
            cnt_q      <= 2'h0;
            instr_done <= 1'b0;
        end else begin
            cnt_q      <= cnt_q + 2'h1;
            instr_done <= !slow || cnt_q == 2'h3;
        end
    end
endmodule : ipta_core_model

/* File: tb/ipta_arbiter_test.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module ipta_arbiter_test;
    import ipta_pkg::*;
    logic        clk, rst, we, cyc, stb, slow, ack, idone, creset, seen;
    logic [31:0] adr, dat_w, dat_o, q;
    logic [53:0] ev;
    logic [23:0] pc;
    ipta_math_s  math;
    ipta_err_s   err;
    ipta_req_s   req;
    int          err_count, checks, cyc_n, i;
    localparam logic [5:0] ETAB [5] = '{6'h20, 6'h10, 6'h08, 6'h0c, 6'h02};
    localparam logic       RTAB [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    localparam logic [1:0] MEN  [6] = '{0, 1, 1, 2, 2, 0};
    localparam logic [5:0] MTAB [6] = '{6'h10, 6'h10, 6'h18, 6'h04, 6'h06, 6'h01};
    localparam logic       TTAB [6] = '{0, 1, 0, 1, 0, 1};
    localparam int         NTAB [4] = '{39, 41, 42, 53};

    ipta_arbiter u_ipta_arbiter (.clk(clk), .rst(rst), .wb_adr_i(adr),
        .wb_dat_i(dat_w), .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack), .src_event(ev),
        .instr_done(idone), .math_in(math), .err_in(err), .core_req(req),
        .core_reset(creset), .program_counter(pc));
    ipta_core_model u_ipta_core_model (.clk(clk), .rst(rst), .slow(slow),
        .core_reset(creset), .instr_done(idone));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task stop_test;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test

    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n == 8000) begin
            err_count++;
            stop_test();
        end
    end

    // one classic cycle, held until ack is sampled
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= {24'h0, a};
        dat_w <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dat_o;
        `CHK("ack", 1'b1, ack)
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : xfer

    task rd(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        `CHK("rdata", e, q)
    endtask : rd

    task fire(input int b);
        @(posedge clk);
        ev <= 54'h1 << b;
        @(posedge clk);
        ev <= '0;
    endtask : fire

    task clr;
        xfer(A_FLAG0, 1'b1, 32'hffffffff);
        xfer(A_FLAG1, 1'b1, 32'h003fffff);
    endtask : clr

    task req_is(input ipta_req_s e);
        repeat (3) @(posedge clk);
        `CHK("core_req", e, req)
    endtask : req_is

    task valid_is(input int n, input logic e);
        repeat (n) @(posedge clk);
        `CHK("valid", e, req.valid)
    endtask : valid_is

    task trap_is(input ipta_req_s e);
        int n;
        n = 0;
        while (req !== e && n < 30) begin
            @(posedge clk);
            n++;
        end
        `CHK("trap req", e, req)
    endtask : trap_is

    task reset_seen(input logic e);
        // first edge after release still shows the reset-held core_reset
        @(posedge clk);
        seen = 1'b0;
        repeat (10) begin
            @(posedge clk);
            seen = seen | creset;
        end
        `CHK("core_reset", e, seen)
    endtask : reset_seen

    task do_reset;
        @(posedge clk);
        rst  <= 1'b1;
        math <= '0;
        err  <= '0;
        repeat (5) @(posedge clk);
        `CHK("reset out", 1'b1, creset)
        `CHK("pc", 24'h000000, pc)
        rst <= 1'b0;
    endtask : do_reset

    initial begin
        {rst, we, cyc, stb, slow, ev, math, err, adr, dat_w} = '0;
        rst = 1'b1;
        err_count = 0;
        checks = 0;
        cyc_n = 0;
        do_reset();
        repeat (10) @(posedge clk);
        `CHK("pc", 24'h000004, pc)
        rd(A_PRIO_BASE, 32'h4444);
        rd(8'hfc, 32'h0);
        xfer(A_PRIO_BASE, 1'b1, 32'hffff);
        rd(A_PRIO_BASE, 32'h7777);
        xfer(A_PRIO_BASE, 1'b1, 32'h4444);
        xfer(A_EN0, 1'b1, 32'hffffffff);
        xfer(A_EN1, 1'b1, 32'h003fffff);
        ev <= 54'h3;
        @(posedge clk);
        ev <= '0;
        req_is({1'b1, 6'h08, 4'h4});
        xfer(A_PRIO_BASE, 1'b1, 32'h0064);
        req_is({1'b1, 6'h09, 4'h6});
        xfer(A_PRIO_BASE, 1'b1, 32'h0004);
        req_is({1'b1, 6'h08, 4'h4});
        xfer(A_PRIO_BASE, 1'b1, 32'h0000);
        valid_is(3, 1'b0);
        xfer(A_PRIO_BASE, 1'b1, 32'h4444);
        xfer(A_CPUIPL, 1'b1, 32'h4);
        valid_is(3, 1'b0);
        xfer(A_CPUIPL, 1'b1, 32'h3);
        req_is({1'b1, 6'h08, 4'h4});
        xfer(A_CPUIPL, 1'b1, 32'h7);
        valid_is(3, 1'b0);
        xfer(A_CPUIPL, 1'b1, 32'h0);
        clr();
        for (i = 0; i < 4; i++) begin
            fire(NTAB[i]);
            if (NTAB[i] == 41 || NTAB[i] == 42)
                req_is({1'b1, 6'(NTAB[i] + 8), 4'h4});
            else
                valid_is(3, 1'b0);
            clr();
        end
        slow <= 1'b1;
        xfer(A_CPUIPL, 1'b1, 32'h7);
        math <= 6'h20;
        trap_is({1'b1, 6'h05, LVL_MATH});
        math <= '0;
        err <= 6'h01;
        trap_is({1'b1, 6'h03, 4'hc});
        for (i = 0; i < 6; i++) begin
            do_reset();
            xfer(A_TRAPCTL, 1'b1, {30'h0, MEN[i]});
            math <= MTAB[i];
            // taken trap masks its own request, so look at the pending bit
            repeat (4) @(posedge clk);
            xfer(A_TRAPSTAT, 1'b0, 32'h0);
            `CHK("math pend", TTAB[i], q[0])
        end
        slow <= 1'b0;
        for (i = 0; i < 5; i++) begin
            do_reset();
            err <= ETAB[i];
            reset_seen(RTAB[i]);
        end
        do_reset();
        math <= 6'h20;
        err <= 6'h01;
        reset_seen(1'b1);
        stop_test();
    end
endmodule : ipta_arbiter_test
